/* shared/smd_pkg.sv */
// Constants, enumerations and carrier structs for the surface message descriptor decoder.
// ===========================================================================
// Overview of operation
// - Typed read/write bit 13 picks header mask half; ignored without header.
// - Bits 11:8 mask alpha, blue, green, red; zero means the channel is present.
// - Untyped read/write bits 13:12: quad read only, sixteen, eight, reserved.
// - Atomic bit 13 enables result writeback; clear means no writeback.
// - Atomic bits 11:8 select the operation from and through pre-decrement.
// - Untyped atomic bit 12 picks sixteen/eight; counter needs 1; 1110b reserved.
// - Counter atomics carry no address; target comes from surface counter field.
// - Counter access with counter disabled is out of bounds: no write, reads zero.
// - Counter atomics share untyped atomic source and writeback formats.
// - Header mask in dword 7 bits 15:0; use depends on slot mode and group.
// - Without a header the header mask behaves as all ones.
// - Payload is addresses, then write data or atomic sources.
// - Address registers are length minus header minus data registers; in two-slot quad mode the code leaves them zero.
// - Atomic read and write to a location are indivisible.
// - Writes outside the surface are dropped.
package smd_pkg;

  // ===========================================================================
  // Descriptor fields
  localparam int DESC_W = 14;
  localparam int SLOT_GROUP_BIT = 13;
  localparam int RETURN_BIT = 13;
  localparam int ATOMIC_SEL_BIT = 12;
  localparam int MODE_HI = 13;
  localparam int MODE_LO = 12;
  localparam int FIELD_HI = 11;
  localparam int FIELD_LO = 8;
  localparam logic [1:0] MODE_CODE_QUAD = 2'h0;
  localparam logic [1:0] MODE_CODE_SIXTEEN = 2'h1;
  localparam logic [1:0] MODE_CODE_EIGHT = 2'h2;
  localparam logic [3:0] CHAN_ALL_MASKED = 4'hF;
  localparam logic [3:0] WMASK_RGBA = 4'h0;
  localparam logic [3:0] WMASK_RGB = 4'h8;
  localparam logic [3:0] WMASK_RG = 4'hC;
  localparam logic [3:0] WMASK_R = 4'hE;

  // ===========================================================================
  // Header and payload sizes
  localparam int MASK_W = 16;
  localparam int HALF_W = 8;
  localparam int QUAD_W = 4;
  localparam int LEN_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] HEADER_REGS = 5'h01;

  // ===========================================================================
  // Register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_LAST_BAD = 8'h08;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CHECK_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int COUNT_W = 16;

  typedef enum logic [3:0] {
    atomic_compare_write_64 = 4'h0, atomic_and = 4'h1, atomic_or = 4'h2,
    atomic_xor = 4'h3, atomic_move = 4'h4, atomic_increment = 4'h5,
    atomic_decrement = 4'h6, atomic_add = 4'h7, atomic_subtract = 4'h8,
    atomic_reverse_subtract = 4'h9, atomic_signed_max = 4'hA,
    atomic_signed_min = 4'hB, atomic_unsigned_max = 4'hC,
    atomic_unsigned_min = 4'hD, atomic_compare_write = 4'hE,
    atomic_pre_decrement = 4'hF
  } smd_atomic_op_type;

  typedef enum logic [3:0] {
    kind_typed_read, kind_typed_write, kind_untyped_read, kind_untyped_write,
    kind_typed_atomic, kind_typed_atomic_quad, kind_untyped_atomic,
    kind_untyped_atomic_quad, kind_counter_atomic, kind_counter_atomic_quad
  } smd_kind_type;

  typedef enum logic [1:0] {
    two_slot_quad_mode, eight_slot_mode, sixteen_slot_mode, reserved_mode
  } smd_mode_type;

  typedef struct packed {
    smd_kind_type kind;
    logic [DESC_W-1:0] desc;
    logic header_present;
    logic [MASK_W-1:0] header_mask;
    logic [MASK_W-1:0] exec_mask;
    logic [LEN_W-1:0] msg_length;
    logic counter_enable;
    logic [DATA_W-1:0] counter_addr;
    logic out_of_bounds;
  } smd_msg_type;

  typedef struct packed {
    smd_kind_type kind;
    smd_mode_type mode;
    logic [3:0] chan_mask;
    logic slot_group;
    logic return_en;
    smd_atomic_op_type op;
    logic [MASK_W-1:0] slot_mask;
    logic [CNT_W-1:0] addr_regs;
    logic [CNT_W-1:0] data_regs;
    logic [CNT_W-1:0] addr_params;
    logic use_counter_addr;
    logic [DATA_W-1:0] target_addr;
    logic mem_modify;
    logic read_zero;
    logic indivisible;
    logic malformed;
  } smd_decode_type;

endpackage : smd_pkg

/* rtl/smd_op_decode.sv */
// Atomic operation code decoder with source register count.
`timescale 1ns/100ps
`default_nettype none
module smd_op_decode (
  // Operation field and message class
  input wire logic [3:0] op_code,
  input wire logic untyped_class,
  input wire logic counter_class,
  // Decoded operation
  output smd_pkg::smd_atomic_op_type op,
  output logic [1:0] source_units,
  output logic op_reserved
);
  import smd_pkg::*;

  // ===========================================================================
  // Decode
  always_comb begin
    op = smd_atomic_op_type'(op_code);
    op_reserved = (op == atomic_compare_write_64) && !untyped_class;
    if (counter_class && op == atomic_compare_write) begin
      op_reserved = 1'b1;
    end
    unique case (op)
      atomic_increment, atomic_decrement, atomic_pre_decrement: source_units = 2'h0;
      atomic_compare_write: source_units = 2'h2;
      // Two 64-bit sources are four eight-slot registers.
      atomic_compare_write_64: source_units = 2'h0;
      default: source_units = 2'h1;
    endcase
  end

endmodule : smd_op_decode
`default_nettype wire

/* rtl/smd_slot_mask.sv */
// Effective slot mask from execution mask and header pixel mask.
`timescale 1ns/100ps
`default_nettype none
module smd_slot_mask (
  // Masks
  input wire logic [15:0] exec_mask,
  input wire logic [15:0] header_mask,
  input wire logic header_present,
  // Selection
  input wire smd_pkg::smd_mode_type mode,
  input wire logic use_high,
  // Result
  output logic [15:0] slot_mask
);
  import smd_pkg::*;

  logic [MASK_W-1:0] hmask;

  always_comb begin
    hmask = header_present ? header_mask : '1;
    slot_mask = '0;
    unique case (mode)
      sixteen_slot_mode: slot_mask = exec_mask & hmask;
      eight_slot_mode: begin
        slot_mask[HALF_W-1:0] = exec_mask[HALF_W-1:0] &
            (use_high ? hmask[MASK_W-1:HALF_W] : hmask[HALF_W-1:0]);
      end
      two_slot_quad_mode: begin
        slot_mask[0] = |exec_mask[QUAD_W-1:0];
        slot_mask[1] = |exec_mask[HALF_W-1:QUAD_W];
      end
      reserved_mode: slot_mask = '0;
    endcase
  end

endmodule : smd_slot_mask
`default_nettype wire

/* rtl/smd_decoder.sv */
// Surface read, write and atomic message descriptor decoder with register port.
`timescale 1ns/100ps
`default_nettype none
module smd_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Incoming message
  input wire logic msg_valid,
  input wire smd_pkg::smd_msg_type msg,
  // Decoded message
  output logic dec_valid,
  output smd_pkg::smd_decode_type dec,
  // Register port
  input wire logic [smd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [smd_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [smd_pkg::DATA_W-1:0] reg_rdata
);
  import smd_pkg::*;

  // ===========================================================================
  // Declarations
  logic [1:0] ctrl_reg;
  logic [COUNT_W-1:0] bad_count_reg;
  logic [COUNT_W-1:0] msg_count_reg;
  logic [DESC_W-1:0] last_bad_desc_reg;
  smd_kind_type last_bad_kind_reg;
  logic dec_valid_reg;
  smd_decode_type dec_reg;
  logic [DATA_W-1:0] rdata_reg;
  smd_decode_type dec_next;
  smd_mode_type mode_next;
  logic group_next;
  logic is_typed_rw;
  logic is_untyped_rw;
  logic is_atomic;
  logic is_counter;
  logic is_untyped_class;
  logic is_quad_variant;
  logic is_write;
  logic is_read;
  logic mode_bad;
  logic issuer_bad;
  logic len_bad;
  logic op_reserved;
  logic [1:0] source_units;
  smd_atomic_op_type op_dec;
  logic [MASK_W-1:0] slot_mask;
  logic [CNT_W-1:0] chan_count;
  logic [CNT_W-1:0] data_units;
  logic [CNT_W-1:0] data_regs;
  logic [CNT_W-1:0] hdr_regs;
  logic [CNT_W-1:0] len_ext;
  logic [CNT_W-1:0] overhead;
  logic [CNT_W-1:0] addr_regs;
  logic [CNT_W-1:0] addr_params;
  logic accept;
  logic [DESC_W-1:0] desc;
  logic [3:0] field;

  // ===========================================================================
  // Message classification
  assign desc = msg.desc;
  assign field = desc[FIELD_HI:FIELD_LO];
  assign is_typed_rw = (msg.kind == kind_typed_read) || (msg.kind == kind_typed_write);
  assign is_untyped_rw = (msg.kind == kind_untyped_read) ||
      (msg.kind == kind_untyped_write);
  assign is_counter = (msg.kind == kind_counter_atomic) ||
      (msg.kind == kind_counter_atomic_quad);
  assign is_atomic = !is_typed_rw && !is_untyped_rw;
  assign is_untyped_class = (msg.kind == kind_untyped_atomic) ||
      (msg.kind == kind_untyped_atomic_quad);
  assign is_quad_variant = (msg.kind == kind_typed_atomic_quad) ||
      (msg.kind == kind_untyped_atomic_quad) ||
      (msg.kind == kind_counter_atomic_quad);
  assign is_write = (msg.kind == kind_typed_write) || (msg.kind == kind_untyped_write);
  assign is_read = (msg.kind == kind_typed_read) || (msg.kind == kind_untyped_read);
  assign accept = msg_valid && ctrl_reg[CTRL_ENABLE_BIT];

  // ===========================================================================
  // Operation decoder
  smd_op_decode u_op (
    .op_code(field),
    .untyped_class(is_untyped_class),
    .counter_class(is_counter),
    .op(op_dec),
    .source_units(source_units),
    .op_reserved(op_reserved)
  );

  // ===========================================================================
  // Slot mode
  always_comb begin
    mode_next = eight_slot_mode;
    mode_bad = 1'b0;
    if (is_untyped_rw) begin
      unique case (desc[MODE_HI:MODE_LO])
        MODE_CODE_QUAD: mode_next = two_slot_quad_mode;
        MODE_CODE_SIXTEEN: mode_next = sixteen_slot_mode;
        MODE_CODE_EIGHT: mode_next = eight_slot_mode;
        default: mode_next = reserved_mode;
      endcase
      mode_bad = (mode_next == reserved_mode) ||
          (mode_next == two_slot_quad_mode && is_write);
    end else if (is_quad_variant) begin
      mode_next = two_slot_quad_mode;
    end else if (msg.kind == kind_untyped_atomic) begin
      mode_next = desc[ATOMIC_SEL_BIT] ? eight_slot_mode : sixteen_slot_mode;
    end else if (msg.kind == kind_counter_atomic) begin
      mode_next = desc[ATOMIC_SEL_BIT] ? eight_slot_mode : reserved_mode;
      mode_bad = !desc[ATOMIC_SEL_BIT];
    end
  end

  // ===========================================================================
  // Slot mask
  always_comb begin
    group_next = 1'b0;
    if (is_typed_rw) begin
      group_next = desc[SLOT_GROUP_BIT];
    end
    if (msg.kind == kind_typed_atomic) begin
      group_next = desc[ATOMIC_SEL_BIT];
    end
  end

  smd_slot_mask u_mask (
    .exec_mask(msg.exec_mask),
    .header_mask(msg.header_mask),
    .header_present(msg.header_present),
    .mode(mode_next),
    .use_high(group_next),
    .slot_mask(slot_mask)
  );

  // ===========================================================================
  // Payload lengths
  always_comb begin
    chan_count = '0;
    for (int i = 0; i < 4; i++) begin
      chan_count = chan_count + {{(CNT_W-1){1'b0}}, ~field[i]};
    end
    data_units = '0;
    if (is_write) begin
      data_units = chan_count;
    end else if (is_atomic) begin
      data_units = (op_dec == atomic_compare_write_64 && is_untyped_class) ?
          5'h04 : {3'h0, source_units};
    end
    data_regs = (mode_next == sixteen_slot_mode) ? {data_units[CNT_W-2:0], 1'b0} :
        data_units;
    hdr_regs = msg.header_present ? HEADER_REGS : '0;
    len_ext = {{(CNT_W-LEN_W){1'b0}}, msg.msg_length};
    overhead = hdr_regs + data_regs;
    addr_regs = '0;
    len_bad = 1'b0;
    if (mode_next == sixteen_slot_mode || mode_next == eight_slot_mode) begin
      if (len_ext < overhead) begin
        len_bad = 1'b1;
      end else begin
        addr_regs = len_ext - overhead;
      end
    end
    if (is_counter) begin
      addr_regs = '0;
      len_bad = len_ext != overhead;
    end
    addr_params = (mode_next == sixteen_slot_mode) ? {1'b0, addr_regs[CNT_W-1:1]} :
        addr_regs;
  end

  // ===========================================================================
  // Issuer checks
  always_comb begin
    issuer_bad = 1'b0;
    if ((is_typed_rw || msg.kind == kind_untyped_read) && field == CHAN_ALL_MASKED) begin
      issuer_bad = 1'b1;
    end
    if (msg.kind == kind_untyped_write && field != WMASK_RGBA && field != WMASK_RGB &&
        field != WMASK_RG && field != WMASK_R) begin
      issuer_bad = 1'b1;
    end
    if ((is_typed_rw || msg.kind == kind_typed_atomic ||
         msg.kind == kind_typed_atomic_quad) && !msg.header_present) begin
      issuer_bad = 1'b1;
    end
  end

  // ===========================================================================
  // Decoded record
  always_comb begin
    dec_next.kind = msg.kind;
    dec_next.mode = mode_next;
    dec_next.slot_group = group_next;
    dec_next.chan_mask = is_atomic ? '0 : field;
    dec_next.return_en = is_atomic ? desc[RETURN_BIT] : is_read;
    dec_next.op = is_atomic ? op_dec : atomic_and;
    dec_next.slot_mask = slot_mask;
    dec_next.addr_regs = addr_regs;
    dec_next.data_regs = data_regs;
    dec_next.addr_params = addr_params;
    dec_next.use_counter_addr = is_counter;
    dec_next.target_addr = is_counter ? msg.counter_addr : '0;
    dec_next.malformed = mode_bad || len_bad || (is_atomic && op_reserved) ||
        (ctrl_reg[CTRL_CHECK_BIT] && issuer_bad);
    dec_next.mem_modify = (is_write || is_atomic) && !dec_next.malformed &&
        !msg.out_of_bounds && !(is_counter && !msg.counter_enable);
    dec_next.read_zero = msg.out_of_bounds || (is_counter && !msg.counter_enable);
    dec_next.indivisible = is_atomic && dec_next.mem_modify;
  end

  // ===========================================================================
  // Output stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dec_valid_reg <= 1'b0;
    end else begin
      dec_valid_reg <= accept;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dec_reg <= '0;
    end else if (accept) begin
      dec_reg <= dec_next;
    end
  end

  // ===========================================================================
  // Registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (reg_write && reg_addr == REG_CTRL) begin
      ctrl_reg <= reg_wdata[1:0];
    end
  end

  // A count write and a new event in one cycle: the event wins over the clear.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bad_count_reg <= '0;
      msg_count_reg <= '0;
    end else begin
      if (accept && dec_next.malformed) begin
        bad_count_reg <= bad_count_reg + 16'h0001;
      end else if (reg_write && reg_addr == REG_STATUS) begin
        bad_count_reg <= '0;
      end
      if (accept) begin
        msg_count_reg <= msg_count_reg + 16'h0001;
      end else if (reg_write && reg_addr == REG_STATUS) begin
        msg_count_reg <= '0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_bad_desc_reg <= '0;
      last_bad_kind_reg <= kind_typed_read;
    end else if (accept && dec_next.malformed) begin
      last_bad_desc_reg <= desc;
      last_bad_kind_reg <= msg.kind;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= '0;
    end else if (reg_read) begin
      unique case (reg_addr)
        REG_CTRL: rdata_reg <= {30'h0000_0000, ctrl_reg};
        REG_STATUS: rdata_reg <= {msg_count_reg, bad_count_reg};
        REG_LAST_BAD: rdata_reg <= {14'h0000, last_bad_kind_reg, last_bad_desc_reg};
        default: rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  assign dec_valid = dec_valid_reg;
  assign dec = dec_reg;
  assign reg_rdata = rdata_reg;

endmodule : smd_decoder
`default_nettype wire

/* tb/smd_sva.sv */
// Port-level assertions for the surface message descriptor decoder.
`timescale 1ns/100ps
`default_nettype none
module smd_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Message side
  input wire logic msg_valid,
  input wire smd_pkg::smd_msg_type msg,
  input wire logic dec_valid,
  input wire smd_pkg::smd_decode_type dec
);
  import smd_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic atom;
  logic cnt;
  assign atom = (dec.kind >= kind_typed_atomic);
  assign cnt = (dec.kind >= kind_counter_atomic);
  // ===========================================================================
  // Assertions
  chk_sixteen_mask: assert property (
    dec_valid && dec.mode == sixteen_slot_mode && $past(msg.header_present)
    |-> dec.slot_mask == ($past(msg.exec_mask) & $past(msg.header_mask)))
    else $error("sixteen slot mask wrong");
  chk_no_header: assert property (
    dec_valid && dec.mode == sixteen_slot_mode && !$past(msg.header_present)
    |-> dec.slot_mask == $past(msg.exec_mask))
    else $error("headerless slot mask wrong");
  chk_return_bit: assert property (
    dec_valid && atom |-> dec.return_en == $past(msg.desc[RETURN_BIT]))
    else $error("return control wrong");
  chk_atomic_op: assert property (
    dec_valid && atom && !dec.malformed && $past(msg.desc[11:8]) != 4'h0
    |-> dec.op == $past(msg.desc[11:8]))
    else $error("atomic operation wrong");
  chk_chan_mask: assert property (
    dec_valid && dec.kind <= kind_untyped_write |-> dec.chan_mask == $past(msg.desc[11:8]))
    else $error("channel mask wrong");
  chk_counter_target: assert property (
    dec_valid && cnt |-> dec.use_counter_addr && dec.addr_regs == 5'h00
    && dec.target_addr == $past(msg.counter_addr))
    else $error("counter target wrong");
  chk_counter_off: assert property (
    dec_valid && cnt && !$past(msg.counter_enable) |-> dec.read_zero && !dec.mem_modify)
    else $error("disabled counter not out of bounds");
  chk_malformed_quiet: assert property (
    dec_valid && dec.malformed |-> !dec.mem_modify)
    else $error("malformed message modifies memory");
  chk_oob_drop: assert property (
    dec_valid && $past(msg.out_of_bounds) |-> !dec.mem_modify)
    else $error("out of bounds write kept");
  chk_mode_reserved: assert property (
    dec_valid && dec.kind inside {kind_untyped_read, kind_untyped_write}
    && $past(msg.desc[13:12]) == 2'h3 |-> dec.malformed)
    else $error("reserved mode not flagged");
  cover property (dec_valid && dec.malformed);
  cover property (dec_valid && dec.use_counter_addr);
  cover property (msg_valid && msg.kind == kind_untyped_atomic);
endmodule : smd_sva
bind smd_decoder smd_sva i_sva (.clk(clk), .resetn(resetn), .msg_valid(msg_valid),
  .msg(msg), .dec_valid(dec_valid), .dec(dec));
`default_nettype wire

/* tb/smd_issuer.sv */
// Issuing-thread model that presents one message per call.
`timescale 1ns/100ps
`default_nettype none
module smd_issuer (
  // Clock
  input wire logic clk,
  // Message out
  output var logic msg_valid,
  output var smd_pkg::smd_msg_type msg
);
  import smd_pkg::*;
  initial begin
    msg_valid = 1'h0;
    msg = '0;
  end
  // Sends one message; bad lets a scenario break the issuer's own duties.
  task automatic send(input smd_msg_type m, input logic bad);
    smd_msg_type t;
    t = m;
    if (!bad) begin
      if (t.kind inside {kind_typed_read, kind_typed_write, kind_typed_atomic,
        kind_typed_atomic_quad}) t.header_present = 1'h1;
      if (t.kind inside {kind_typed_read, kind_typed_write, kind_untyped_read}
        && t.desc[11:8] == CHAN_ALL_MASKED) t.desc[11:8] = WMASK_RGBA;
      if (t.kind == kind_untyped_write
        && !(t.desc[11:8] inside {WMASK_RGBA, WMASK_RGB, WMASK_RG, WMASK_R}))
        t.desc[11:8] = WMASK_RGBA;
    end
    @(posedge clk);
    msg_valid <= 1'h1;
    msg <= t;
    @(posedge clk);
    msg_valid <= 1'h0;
    // Idle lines show the inverse, so a decoder latching late sees garbage.
    msg <= smd_msg_type'(~t);
  endtask : send
endmodule : smd_issuer
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the surface message descriptor decoder.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import smd_pkg::*;
  logic clk;
  logic resetn;
  logic msg_valid;
  smd_msg_type msg;
  logic dec_valid;
  smd_decode_type dec;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [DATA_W-1:0] reg_rdata;
  int bad_count;
  int num_checks;
  smd_issuer i_iss (.clk(clk), .msg_valid(msg_valid), .msg(msg));
  smd_decoder i_dut (.clk(clk), .resetn(resetn), .msg_valid(msg_valid), .msg(msg),
    .dec_valid(dec_valid), .dec(dec), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // ===========================================================================
  // Helpers
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic smd_msg_type mk(input smd_kind_type k, input logic [5:0] f,
    input logic [15:0] hm, input logic [15:0] em, input logic [3:0] len);
    mk = '0;
    mk.kind = k;
    mk.desc = {f, 8'h00};
    mk.header_present = 1'h1;
    mk.header_mask = hm;
    mk.exec_mask = em;
    mk.msg_length = len;
    mk.counter_enable = 1'h1;
  endfunction : mk
  function automatic logic [3:0] nsrc(input logic [3:0] c);
    case (c)
      4'h0: nsrc = 4'h4;
      4'h5, 4'h6, 4'hF: nsrc = 4'h0;
      4'hE: nsrc = 4'h2;
      default: nsrc = 4'h1;
    endcase
  endfunction : nsrc
  task automatic go(input smd_msg_type m, input logic bad);
    i_iss.send(m, bad);
    #1;
    chk("dec_valid", 1'h1, dec_valid);
  endtask : go
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_read <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'h0;
    #1;
    d = reg_rdata;
  endtask : rd
  // ===========================================================================
  // Scenarios
  task automatic t_regs();
    logic [31:0] v;
    smd_msg_type m;
    rd(REG_CTRL, v);
    chk("ctrl_reset", 2'h3, v);
    wr(REG_STATUS, 32'h0000_0000);
    go(mk(kind_untyped_read, 6'h10, 16'hFFFF, 16'hFFFF, 4'h5), 1'h0);
    m = mk(kind_untyped_read, 6'h30, 16'hFFFF, 16'hFFFF, 4'h5);
    go(m, 1'h0);
    rd(REG_STATUS, v);
    chk("status", 32'h0002_0001, v);
    rd(REG_LAST_BAD, v);
    chk("last_bad", 32'h0000_B000, v);
    wr(REG_CTRL, 32'h0000_0002);
    i_iss.send(m, 1'h0);
    #1;
    chk("refused_valid", 1'h0, dec_valid);
    rd(REG_STATUS, v);
    chk("status_held", 32'h0002_0001, v);
    rd(8'h0C, v);
    chk("unmapped", 32'h0000_0000, v);
    wr(REG_CTRL, 32'h0000_0003);
    $display("test registers done");
  endtask : t_regs
  task automatic t_typed();
    go(mk(kind_typed_read, 6'h26, 16'hA53C, 16'h00FF, 4'h3), 1'h0);
    chk("group_hi", 8'hA5, dec.slot_mask[7:0]);
    chk("chan_mask", 4'h6, dec.chan_mask);
    chk("group_sel", 1'h1, dec.slot_group);
    chk("kind", kind_typed_read, dec.kind);
    go(mk(kind_typed_write, 6'h08, 16'hA53C, 16'h00F0, 4'h6), 1'h0);
    chk("group_lo", 8'h30, dec.slot_mask[7:0]);
    chk("write_data", 5'h03, dec.data_regs);
    $display("test typed done");
  endtask : t_typed
  task automatic t_untyped();
    smd_msg_type m;
    go(mk(kind_untyped_read, 6'h10, 16'h3333, 16'hF0F0, 4'h5), 1'h0);
    chk("mode16", sixteen_slot_mode, dec.mode);
    chk("mask16", 16'h3030, dec.slot_mask);
    chk("read_addr", 5'h04, dec.addr_regs);
    chk("read_params", 5'h02, dec.addr_params);
    m = mk(kind_untyped_write, 6'h2C, 16'h0000, 16'hFFAA, 4'h5);
    m.header_present = 1'h0;
    go(m, 1'h0);
    chk("mask8", 8'hAA, dec.slot_mask[7:0]);
    chk("w8_data", 5'h02, dec.data_regs);
    chk("w8_addr", 5'h03, dec.addr_regs);
    chk("w8_modify", 1'h1, dec.mem_modify);
    m = mk(kind_untyped_write, 6'h18, 16'h0000, 16'h1234, 4'h8);
    m.header_present = 1'h0;
    go(m, 1'h0);
    chk("nohdr16", 16'h1234, dec.slot_mask);
    chk("w16_data", 5'h06, dec.data_regs);
    chk("w16_params", 5'h01, dec.addr_params);
    go(mk(kind_untyped_read, 6'h00, 16'hFFFF, 16'h0010, 4'h2), 1'h0);
    chk("quad_mode", two_slot_quad_mode, dec.mode);
    chk("quad_mask", 2'h2, dec.slot_mask[1:0]);
    go(mk(kind_untyped_atomic_quad, 6'h20, 16'h0000, 16'h00F0, 4'h2), 1'h0);
    chk("qatom_mode", two_slot_quad_mode, dec.mode);
    chk("qatom_mask", 2'h2, dec.slot_mask[1:0]);
    chk("qatom_cmp64", 1'h0, dec.malformed);
    go(mk(kind_untyped_write, 6'h00, 16'hFFFF, 16'h00FF, 4'h6), 1'h0);
    chk("quad_write", 1'h1, dec.malformed);
    $display("test untyped done");
  endtask : t_untyped
  task automatic t_ops();
    logic [3:0] n;
    for (int i = 0; i < 16; i++) begin
      n = nsrc(i[3:0]);
      go(mk(kind_untyped_atomic, {i[0], 1'h1, i[3:0]}, 16'hFFFF, 16'h00FF, 4'h2 + n), 1'h0);
      chk("op", i[3:0], dec.op);
      chk("src_regs", n, dec.data_regs);
      chk("return", i[0], dec.return_en);
      chk("whole", 1'h1, dec.indivisible);
    end
    go(mk(kind_untyped_atomic, 6'h0E, 16'hFFFF, 16'hFFFF, 4'h7), 1'h0);
    chk("cmp16_data", 5'h04, dec.data_regs);
    chk("cmp16_addr", 5'h02, dec.addr_regs);
    go(mk(kind_typed_atomic, 6'h17, 16'h5A00, 16'h00FF, 4'h3), 1'h0);
    chk("atom_group", 8'h5A, dec.slot_mask[7:0]);
    $display("test atomics done");
  endtask : t_ops
  task automatic t_reserved();
    smd_msg_type m [4];
    m[0] = mk(kind_typed_atomic, 6'h20, 16'hFFFF, 16'h00FF, 4'h3);
    m[1] = mk(kind_counter_atomic, 6'h1E, 16'hFFFF, 16'h00FF, 4'h3);
    m[2] = mk(kind_counter_atomic, 6'h07, 16'hFFFF, 16'h00FF, 4'h2);
    m[3] = mk(kind_counter_atomic_quad, 6'h00, 16'hFFFF, 16'h00FF, 4'h2);
    for (int i = 0; i < 4; i++) begin
      go(m[i], 1'h0);
      chk("reserved", 1'h1, dec.malformed);
      chk("reserved_modify", 1'h0, dec.mem_modify);
    end
    $display("test reserved done");
  endtask : t_reserved
  task automatic t_counter();
    smd_msg_type m;
    m = mk(kind_counter_atomic, 6'h37, 16'hFFFF, 16'h00FF, 4'h2);
    m.counter_addr = 32'h1234_5678;
    go(m, 1'h0);
    chk("target", 32'h1234_5678, dec.target_addr);
    chk("cnt_addr", 5'h00, dec.addr_regs);
    chk("cnt_data", 5'h01, dec.data_regs);
    chk("cnt_modify", 1'h1, dec.mem_modify);
    m.counter_enable = 1'h0;
    go(m, 1'h0);
    chk("cnt_zero", 1'h1, dec.read_zero);
    chk("cnt_drop", 1'h0, dec.mem_modify);
    m = mk(kind_untyped_write, 6'h20, 16'hFFFF, 16'h00FF, 4'h6);
    m.out_of_bounds = 1'h1;
    go(m, 1'h0);
    chk("oob_drop", 1'h0, dec.mem_modify);
    go(mk(kind_untyped_write, 6'h24, 16'hFFFF, 16'h00FF, 4'h6), 1'h1);
    chk("bad_wmask", 1'h1, dec.malformed);
    $display("test counter done");
  endtask : t_counter
  // ===========================================================================
  // Sequence and verdict
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  initial begin
    resetn = 1'h0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'h0;
    reg_read = 1'h0;
    repeat (3) @(posedge clk);
    resetn <= 1'h1;
    t_regs();
    t_typed();
    t_untyped();
    t_ops();
    t_reserved();
    t_counter();
    give_verdict();
  end
  // The full run needs well under a thousand cycles; this cuts a hang short.
  initial begin
    #20000;
    bad_count++;
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
